// *** design/dso_pkg.sv ***
/*
 * Shared constants of the drive status output block: register map,
 * field positions, reset values and terminal numbering.
 * Assumes a 32-bit Avalon-MM slave port addressed in bytes.
 */
package dso_pkg;

    localparam int unsigned ADDR_W   = 5;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned THR_W    = 14;
    localparam int unsigned SPEED_W  = 16;
    localparam int unsigned CODE_W   = 3;
    localparam int unsigned ASSIGN_W = 2;
    localparam int unsigned TERM_N   = 3;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [ADDR_W-1:0] CONFIG_OFS = 5'h00;
    localparam logic [ADDR_W-1:0] THRESH_OFS = 5'h04;
    localparam logic [ADDR_W-1:0] ASSIGN_OFS = 5'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h0C;

    ////////////////////////////////////////////////////////////////////////
    // CONFIG fields
    localparam int unsigned CFG_SEL_BIT    = 0;
    localparam int unsigned CFG_ABS_BIT    = 1;
    localparam int unsigned CFG_NOHALL_BIT = 2;
    localparam int unsigned CFG_APPLY_BIT  = 7;
    localparam int unsigned CFG_SEL_ACT    = 8;

    // ASSIGN fields: 0 means unassigned, 1..3 select a terminal
    localparam int unsigned ASG_WARN_LSB   = 0;
    localparam int unsigned ASG_MOTION_LSB = 4;
    localparam int unsigned ASG_READY_LSB  = 8;

    // STATUS fields
    localparam int unsigned ST_FAULT_BIT   = 0;
    localparam int unsigned ST_SCALE_BIT   = 1;
    localparam int unsigned ST_HARDWIRED_BLOCKING_BIT    = 2;
    localparam int unsigned ST_READY_BIT   = 3;
    localparam int unsigned ST_MOTION_BIT  = 4;
    localparam int unsigned ST_WARN_BIT    = 5;
    localparam int unsigned ST_FIRST_BIT   = 6;
    localparam int unsigned ST_CODE_LSB    = 8;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and limits
    localparam logic [THR_W-1:0]    THRESH_RST    = 14'h0014;
    localparam logic [THR_W-1:0]    THRESH_MIN    = 14'h0001;
    localparam logic [THR_W-1:0]    THRESH_MAX    = 14'h2710;
    localparam logic [ASSIGN_W-1:0] WARN_ASG_RST  = 2'h0;
    localparam logic [ASSIGN_W-1:0] MOTION_ASG_RST = 2'h1;
    localparam logic [ASSIGN_W-1:0] READY_ASG_RST = 2'h2;
    localparam logic [CODE_W-1:0]   CODE_NONE     = 3'h0;
    localparam logic [DATA_W-1:0]   RDATA_NONE    = 32'h0000_0000;

endpackage

// *** design/dso_sync.sv ***
/*
 * Two-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes pins change slowly against clk_i.
 */
`timescale 1ns/10ps

module dso_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dso_sync_t;

    dso_sync_t s_q;
    dso_sync_t s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d        = s_q;
        s_d.meta   = async_i;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= {RST_VAL, RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.stable;

endmodule

// *** design/dso_pin_router.sv ***
/*
 * Routes warning, motion and ready levels onto output terminals
 * per the assignment fields; registered.
 * Assumes assignments come from same-domain registers.
 */
`timescale 1ns/10ps

module dso_pin_router
    import dso_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                warn_i,
    input  wire logic                motion_i,
    input  wire logic                ready_i,
    input  wire logic [ASSIGN_W-1:0] warn_asg_i,
    input  wire logic [ASSIGN_W-1:0] motion_asg_i,
    input  wire logic [ASSIGN_W-1:0] ready_asg_i,
    output logic      [TERM_N-1:0]   term_o
);

    typedef struct packed {
        logic [TERM_N-1:0] term;
    } dso_route_t;

    dso_route_t r_q;
    dso_route_t r_d;

    // Two signals on one terminal are ORed; software should avoid it
    always_comb begin
        r_d = r_q;
        for (int k = 0; k < TERM_N; k++) begin
            r_d.term[k] = (warn_i   && (warn_asg_i   == ASSIGN_W'(k + 1))) ||
                          (motion_i && (motion_asg_i == ASSIGN_W'(k + 1))) ||
                          (ready_i  && (ready_asg_i  == ASSIGN_W'(k + 1)));
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign term_o = r_q.term;

endmodule

// *** design/dso_status_top.sv ***
/*
 * Drive status outputs: fault latch and fault code pins, warning,
 * motion detect and ready outputs, with an Avalon-MM register slave.
 * Assumes drive-internal events arrive on clk_i; pins are asynchronous.
 */
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/10ps

module dso_status_top
    import dso_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]  avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [DATA_W-1:0]  avs_writedata_i,
    output logic      [DATA_W-1:0]  avs_readdata_o,
    output logic                    avs_waitrequest_o,
    // Drive-internal sources, same clock
    input  wire logic               fault_event_i,
    input  wire logic [CODE_W-1:0]  fault_type_i,
    input  wire logic               fault_is_scale_i,
    input  wire logic               warning_i,
    input  wire logic [CODE_W-1:0]  warning_type_i,
    input  wire logic [SPEED_W-1:0] motor_speed_i,
    input  wire logic               handheld_reset_i,
    input  wire logic               drive_enable_command_i,
    input  wire logic               polarity_done_i,
    input  wire logic               abs_transfer_done_i,
    // Pins, asynchronous
    input  wire logic               fault_clear_in_i,
    input  wire logic               panel_up_key_i,
    input  wire logic               panel_down_key_i,
    input  wire logic               main_power_on_i,
    input  wire logic               safe_stop_in_a_i,
    input  wire logic               safe_stop_in_b_i,
    input  wire logic               absolute_data_request_i,
    // Status pins, 1 = closed
    output logic                    fault_status_out_o,
    output logic                    fault_code_bit0_o,
    output logic                    fault_code_bit1_o,
    output logic                    fault_code_bit2_o,
    output logic      [TERM_N-1:0]  out_terminal_o,
    output logic                    polarity_start_o
);

    typedef struct packed {
        logic                bus_wait;
        logic [DATA_W-1:0]   rdata;
        logic                sel_pend;
        logic                sel_act;
        logic                abs_mode;
        logic                no_hall;
        logic [THR_W-1:0]    thresh;
        logic [ASSIGN_W-1:0] warn_asg;
        logic [ASSIGN_W-1:0] motion_asg;
        logic [ASSIGN_W-1:0] ready_asg;
        logic                fault;
        logic                scale_fault;
        logic [CODE_W-1:0]   fault_type;
        logic                clr_prev;
        logic                keys_prev;
        logic                enable_prev;
        logic                first_seen;
        logic                pol_start;
        logic                alm_out;
        logic [CODE_W-1:0]   code_out;
        logic                warn_lvl;
        logic                motion_lvl;
        logic                ready_lvl;
        logic                hardwired_blocking;
    } dso_state_t;

    localparam int unsigned PIN_N = 7;

    dso_state_t         s_q;
    dso_state_t         s_d;
    logic [PIN_N-1:0]   pins_raw;
    logic [PIN_N-1:0]   pins_s;
    logic               clr_s;
    logic               up_s;
    logic               down_s;
    logic               power_s;
    logic               stop_a_s;
    logic               stop_b_s;
    logic               sen_s;

    function automatic logic rise(input logic prev, input logic cur);
        return cur && !prev;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; safety stops reset to OFF so blocking holds early

    assign pins_raw = {fault_clear_in_i, panel_up_key_i, panel_down_key_i,
                       main_power_on_i, safe_stop_in_a_i, safe_stop_in_b_i,
                       absolute_data_request_i};

    dso_sync #(
        .WIDTH   (PIN_N),
        .RST_VAL ('0)
    ) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (pins_raw),
        .sync_o    (pins_s)
    );

    assign {clr_s, up_s, down_s, power_s, stop_a_s, stop_b_s, sen_s} = pins_s;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic               clr_req;
        logic               keys;
        logic               pol_ok;
        logic               abs_ok;
        logic [DATA_W-1:0]  rd;
        logic               take;
        logic [THR_W-1:0]   wthr;

        s_d     = s_q;
        keys    = up_s && down_s;
        clr_req = rise(s_q.clr_prev, clr_s) ||
                  rise(s_q.keys_prev, keys) ||
                  handheld_reset_i;
        take    = (avs_read_i || avs_write_i) && !s_q.bus_wait;
        wthr    = avs_writedata_i[THR_W-1:0];
        rd      = RDATA_NONE;

        // One wait cycle, then the request is taken
        if ((avs_read_i || avs_write_i) && s_q.bus_wait) begin
            s_d.bus_wait = 1'b0;
        end else begin
            s_d.bus_wait = 1'b1;
        end

        unique case (avs_address_i)
            CONFIG_OFS: begin
                rd[CFG_SEL_BIT]    = s_q.sel_pend;
                rd[CFG_ABS_BIT]    = s_q.abs_mode;
                rd[CFG_NOHALL_BIT] = s_q.no_hall;
                rd[CFG_SEL_ACT]    = s_q.sel_act;
            end
            THRESH_OFS: rd[THR_W-1:0] = s_q.thresh;
            ASSIGN_OFS: begin
                rd[ASG_WARN_LSB +: ASSIGN_W]   = s_q.warn_asg;
                rd[ASG_MOTION_LSB +: ASSIGN_W] = s_q.motion_asg;
                rd[ASG_READY_LSB +: ASSIGN_W]  = s_q.ready_asg;
            end
            STATUS_OFS: begin
                rd[ST_FAULT_BIT]             = s_q.fault;
                rd[ST_SCALE_BIT]             = s_q.scale_fault;
                rd[ST_HARDWIRED_BLOCKING_BIT]              = s_q.hardwired_blocking;
                rd[ST_READY_BIT]             = s_q.ready_lvl;
                rd[ST_MOTION_BIT]            = s_q.motion_lvl;
                rd[ST_WARN_BIT]              = s_q.warn_lvl;
                rd[ST_FIRST_BIT]             = s_q.first_seen;
                rd[ST_CODE_LSB +: CODE_W]    = s_q.fault_type;
            end
            default: rd = RDATA_NONE;
        endcase
        if (avs_read_i && s_q.bus_wait) begin
            s_d.rdata = rd;
        end

        if (take && avs_write_i) begin
            unique case (avs_address_i)
                CONFIG_OFS: begin
                    s_d.sel_pend = avs_writedata_i[CFG_SEL_BIT];
                    s_d.abs_mode = avs_writedata_i[CFG_ABS_BIT];
                    s_d.no_hall  = avs_writedata_i[CFG_NOHALL_BIT];
                    // Soft restart applies the written select
                    if (avs_writedata_i[CFG_APPLY_BIT]) begin
                        s_d.sel_act = avs_writedata_i[CFG_SEL_BIT];
                    end
                end
                THRESH_OFS: begin
                    // Out-of-range writes keep the old value
                    if (wthr >= THRESH_MIN && wthr <= THRESH_MAX &&
                        avs_writedata_i[DATA_W-1:THR_W] == '0) begin
                        s_d.thresh = wthr;
                    end
                end
                ASSIGN_OFS: begin
                    s_d.warn_asg   = avs_writedata_i[ASG_WARN_LSB +: ASSIGN_W];
                    s_d.motion_asg = avs_writedata_i[ASG_MOTION_LSB +: ASSIGN_W];
                    s_d.ready_asg  = avs_writedata_i[ASG_READY_LSB +: ASSIGN_W];
                end
                default: begin
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Fault latch: a new fault in the clear cycle stays latched
        s_d.clr_prev  = clr_s;
        s_d.keys_prev = keys;
        if (clr_req && !s_q.scale_fault) begin
            s_d.fault = 1'b0;
        end
        if (fault_event_i) begin
            s_d.fault       = 1'b1;
            s_d.fault_type  = fault_type_i;
            s_d.scale_fault = s_q.scale_fault || fault_is_scale_i;
        end

        s_d.alm_out = !s_d.fault;
        if (s_d.fault) begin
            s_d.code_out = s_d.fault_type;
        end else if (s_q.sel_act && warning_i) begin
            s_d.code_out = warning_type_i;
        end else begin
            s_d.code_out = CODE_NONE;
        end

        s_d.warn_lvl   = warning_i;
        s_d.motion_lvl = motor_speed_i >= SPEED_W'(s_q.thresh);
        s_d.hardwired_blocking       = !stop_a_s || !stop_b_s;

        ////////////////////////////////////////////////////////////////////
        // First enable starts polarity detection
        s_d.enable_prev = drive_enable_command_i;
        s_d.pol_start   = 1'b0;
        if (rise(s_q.enable_prev, drive_enable_command_i) && !s_q.first_seen) begin
            s_d.first_seen = 1'b1;
            s_d.pol_start  = s_q.no_hall;
        end
        pol_ok = !s_q.no_hall || polarity_done_i || !s_q.first_seen;
        abs_ok = !s_q.abs_mode || (sen_s && abs_transfer_done_i);

        s_d.ready_lvl = power_s && !s_d.hardwired_blocking && !s_d.fault &&
                        abs_ok && pol_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q            <= '0;
            s_q.bus_wait   <= 1'b1;
            s_q.thresh     <= THRESH_RST;
            s_q.warn_asg   <= WARN_ASG_RST;
            s_q.motion_asg <= MOTION_ASG_RST;
            s_q.ready_asg  <= READY_ASG_RST;
            s_q.hardwired_blocking       <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Terminal routing

    dso_pin_router u_router (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .warn_i       (s_q.warn_lvl),
        .motion_i     (s_q.motion_lvl),
        .ready_i      (s_q.ready_lvl),
        .warn_asg_i   (s_q.warn_asg),
        .motion_asg_i (s_q.motion_asg),
        .ready_asg_i  (s_q.ready_asg),
        .term_o       (out_terminal_o)
    );

    assign avs_readdata_o     = s_q.rdata;
    assign avs_waitrequest_o  = s_q.bus_wait;
    assign fault_status_out_o = s_q.alm_out;
    assign fault_code_bit0_o  = s_q.code_out[0];
    assign fault_code_bit1_o  = s_q.code_out[1];
    assign fault_code_bit2_o  = s_q.code_out[2];
    assign polarity_start_o   = s_q.pol_start;

endmodule

// *** bench/dso_status_props.sv ***
/* Checker bound to dso_status_top.
   Assumes one clock; sees only top-level ports. */
`timescale 1ns/10ps
module dso_status_props
    import dso_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic              avs_waitrequest_o,
    input  wire logic              fault_event_i,
    input  wire logic [CODE_W-1:0] fault_type_i,
    input  wire logic              fault_is_scale_i,
    input  wire logic              handheld_reset_i,
    input  wire logic              main_power_on_i,
    input  wire logic              safe_stop_in_a_i,
    input  wire logic              fault_status_out_o,
    input  wire logic              fault_code_bit0_o,
    input  wire logic              fault_code_bit1_o,
    input  wire logic              fault_code_bit2_o,
    input  wire logic [TERM_N-1:0] out_terminal_o
);
    logic scale_q;
    logic scale_d;
    // Scale fault seen; only reset forgets it
    assign scale_d = scale_q | (fault_event_i & fault_is_scale_i);
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scale_q <= 1'b0;
        end else begin
            scale_q <= scale_d;
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////
    wait_accept_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not accepted");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest held low");
    fault_open_a: assert property (fault_event_i |=> !fault_status_out_o)
        else $error("fault output closed");
    fault_code_a: assert property (fault_event_i && fault_status_out_o |=>
        {fault_code_bit2_o, fault_code_bit1_o, fault_code_bit0_o} == $past(fault_type_i))
        else $error("wrong fault code");
    scale_hold_a: assert property (scale_q |-> !fault_status_out_o)
        else $error("scale fault cleared");
    hand_clear_a: assert property (handheld_reset_i && !fault_status_out_o && !scale_q && !fault_event_i
        |=> fault_status_out_o)
        else $error("handheld clear missed");
    // Six cycles cover the pipeline
    block_ready_a: assert property (!safe_stop_in_a_i [*6] |-> !out_terminal_o[1])
        else $error("ready while blocked");
    power_ready_a: assert property (!main_power_on_i [*6] |-> !out_terminal_o[1])
        else $error("ready without power");
endmodule

// *** bench/dso_host_model.sv ***
/* Host model: drives fault clear, data request, main power.
   Assumes requests change after rising edges. */
`timescale 1ns/10ps
module dso_host_model (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic fault_status_out_i,
    input  wire logic pwr_en_i,
    input  wire logic clear_req_i,
    input  wire logic sen_req_i,
    output logic      fault_clear_in_o,
    output logic      absolute_data_request_o,
    output logic      main_power_on_o
);
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fault_clear_in_o        <= 1'b0;
            absolute_data_request_o <= 1'b0;
            main_power_on_o         <= 1'b0;
        end else begin
            fault_clear_in_o        <= clear_req_i;
            absolute_data_request_o <= sen_req_i;
            // Open fault output cuts main power one clock later
            main_power_on_o         <= pwr_en_i & fault_status_out_i;
        end
    end
endmodule

// *** bench/dso_status_top_tb.sv ***
/* Bench of dso_status_top with host model and checker.
   Assumes checker and host model compiled first. */
`timescale 1ns/10ps
module dso_status_top_tb;
    import dso_pkg::*;
    logic clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, fault_event_i, fault_is_scale_i;
    logic warning_i, handheld_reset_i, drive_enable_command_i, polarity_done_i, abs_transfer_done_i;
    logic fault_clear_in_i, panel_up_key_i, panel_down_key_i, main_power_on_i, safe_stop_in_a_i;
    logic safe_stop_in_b_i, absolute_data_request_i, fault_status_out_o, polarity_start_o;
    logic fault_code_bit0_o, fault_code_bit1_o, fault_code_bit2_o, pwr_en, clr_req, sen_req, pin_go;
    logic [ADDR_W-1:0]  avs_address_i;
    logic [DATA_W-1:0]  avs_writedata_i, avs_readdata_o;
    logic [CODE_W-1:0]  fault_type_i, warning_type_i, ft;
    logic [SPEED_W-1:0] motor_speed_i;
    logic [TERM_N-1:0]  out_terminal_o;
    logic [1:0]         pol_cnt, pe;
    logic [63:0]        rd_q[$];
    logic [8:0]         pin_q[$];
    int                 num_errors, checks_done;
    dso_status_top u_dut (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_readdata_o, .avs_waitrequest_o, .fault_event_i, .fault_type_i, .fault_is_scale_i, .warning_i,
        .warning_type_i, .motor_speed_i, .handheld_reset_i, .drive_enable_command_i, .polarity_done_i,
        .abs_transfer_done_i, .fault_clear_in_i, .panel_up_key_i, .panel_down_key_i, .main_power_on_i,
        .safe_stop_in_a_i, .safe_stop_in_b_i, .absolute_data_request_i, .fault_status_out_o,
        .fault_code_bit0_o, .fault_code_bit1_o, .fault_code_bit2_o, .out_terminal_o, .polarity_start_o);
    dso_host_model u_host (.clk_i, .sys_rst_i, .fault_status_out_i(fault_status_out_o), .pwr_en_i(pwr_en),
        .clear_req_i(clr_req), .sen_req_i(sen_req), .fault_clear_in_o(fault_clear_in_i),
        .absolute_data_request_o(absolute_data_request_i), .main_power_on_o(main_power_on_i));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic fail(input string m);
        num_errors++;
        $display("FAIL at %0t: %s", $time, m);
    endtask
    task automatic summarize();
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Negedge sees settled outputs
    always @(negedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && rd_q.size() > 0) begin
            checks_done++;
            if ((avs_readdata_o & rd_q[0][31:0]) !== rd_q[0][63:32]) fail("read data mismatch");
            void'(rd_q.pop_front());
        end
        if (pin_go && pin_q.size() > 0) begin
            checks_done++;
            if ({pol_cnt, out_terminal_o, fault_code_bit2_o, fault_code_bit1_o, fault_code_bit0_o,
                 fault_status_out_o} !== pin_q[0]) fail("status pins mismatch");
            void'(pin_q.pop_front());
        end
    end
    always @(posedge clk_i) begin
        if (sys_rst_i) pol_cnt <= 2'h0;
        else if (polarity_start_o === 1'b1) pol_cnt <= pol_cnt + 2'h1;
    end
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= ~w;
        avs_write_i <= w;
        do begin
            @(negedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) fail("bus request hung");
        @(posedge clk_i);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
        rd_q.push_back({e, m});
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // Ten cycles outlast all pipeline stages
    task automatic p(input logic [2:0] t, input logic [2:0] c, input logic ok);
        repeat (10) @(posedge clk_i);
        pin_q.push_back({pe, t, c, ok});
        pin_go <= 1'b1;
        @(posedge clk_i);
        pin_go <= 1'b0;
    endtask
    task automatic fe(input logic [2:0] t, input logic s);
        fault_event_i <= 1'b1;
        fault_type_i <= t;
        fault_is_scale_i <= s;
        @(posedge clk_i);
        fault_event_i <= 1'b0;
    endtask
    task automatic clrp();
        clr_req <= 1'b1;
        repeat (3) @(posedge clk_i);
        clr_req <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int s;
        {avs_read_i, avs_write_i, fault_event_i, fault_is_scale_i, warning_i, handheld_reset_i} = '0;
        {drive_enable_command_i, polarity_done_i, abs_transfer_done_i, panel_up_key_i} = '0;
        {panel_down_key_i, clr_req, sen_req, pin_go} = '0;
        {sys_rst_i, pwr_en, safe_stop_in_a_i, safe_stop_in_b_i} = 4'hF;
        {avs_address_i, avs_writedata_i, fault_type_i, motor_speed_i, pe} = '0;
        warning_type_i = 3'h3;
        num_errors = 0;
        checks_done = 0;
        void'($urandom(65825));
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(CONFIG_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(THRESH_OFS, 32'(THRESH_RST), 32'hFFFF_FFFF);
        rd(ASSIGN_OFS, 32'h0000_0210, 32'h0000_0333);
        rd(5'h10, 32'h0000_0000, 32'hFFFF_FFFF);
        p(3'b010, 3'h0, 1'b1);
        motor_speed_i <= 16'h0014;
        p(3'b011, 3'h0, 1'b1);
        motor_speed_i <= 16'h0013;
        p(3'b010, 3'h0, 1'b1);
        bus(1'b1, THRESH_OFS, 32'h0000_2710);
        bus(1'b1, THRESH_OFS, 32'h0000_2711);
        bus(1'b1, THRESH_OFS, 32'h0000_0000);
        rd(THRESH_OFS, 32'(THRESH_MAX), 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) begin
            s = $urandom_range(9998, 10002);
            motor_speed_i <= s[SPEED_W-1:0];
            p({2'b01, s >= 10000}, 3'h0, 1'b1);
        end
        motor_speed_i <= 16'h0000;
        pwr_en <= 1'b0;
        p(3'b000, 3'h0, 1'b1);
        pwr_en <= 1'b1;
        safe_stop_in_a_i <= 1'b0;
        p(3'b000, 3'h0, 1'b1);
        {safe_stop_in_a_i, safe_stop_in_b_i} <= 2'b10;
        p(3'b000, 3'h0, 1'b1);
        safe_stop_in_b_i <= 1'b1;
        p(3'b010, 3'h0, 1'b1);
        ft = 3'($urandom_range(1, 7));
        fe(ft, 1'b0);
        p(3'b000, ft, 1'b0);
        clrp();
        p(3'b010, 3'h0, 1'b1);
        clr_req <= 1'b1;
        repeat (5) @(posedge clk_i);
        fe(3'h5, 1'b0);
        p(3'b000, 3'h5, 1'b0);
        clr_req <= 1'b0;
        p(3'b000, 3'h5, 1'b0);
        clrp();
        p(3'b010, 3'h0, 1'b1);
        fe(3'h2, 1'b0);
        panel_up_key_i <= 1'b1;
        p(3'b000, 3'h2, 1'b0);
        panel_down_key_i <= 1'b1;
        p(3'b010, 3'h0, 1'b1);
        {panel_up_key_i, panel_down_key_i} <= 2'b00;
        fe(3'h3, 1'b0);
        handheld_reset_i <= 1'b1;
        @(posedge clk_i);
        handheld_reset_i <= 1'b0;
        p(3'b010, 3'h0, 1'b1);
        warning_i <= 1'b1;
        p(3'b010, 3'h0, 1'b1);
        bus(1'b1, ASSIGN_OFS, 32'h0000_0213);
        p(3'b110, 3'h0, 1'b1);
        bus(1'b1, CONFIG_OFS, 32'h0000_0001);
        p(3'b110, 3'h0, 1'b1);
        bus(1'b1, CONFIG_OFS, 32'h0000_0081);
        rd(CONFIG_OFS, 32'h0000_0101, 32'h0000_0101);
        p(3'b110, 3'h3, 1'b1);
        fe(3'h6, 1'b0);
        p(3'b100, 3'h6, 1'b0);
        clrp();
        p(3'b110, 3'h3, 1'b1);
        warning_i <= 1'b0;
        p(3'b010, 3'h0, 1'b1);
        bus(1'b1, ASSIGN_OFS, 32'h0000_0310);
        p(3'b100, 3'h0, 1'b1);
        bus(1'b1, ASSIGN_OFS, 32'h0000_0210);
        bus(1'b1, CONFIG_OFS, 32'h0000_0003);
        p(3'b000, 3'h0, 1'b1);
        sen_req <= 1'b1;
        p(3'b000, 3'h0, 1'b1);
        abs_transfer_done_i <= 1'b1;
        p(3'b010, 3'h0, 1'b1);
        bus(1'b1, CONFIG_OFS, 32'h0000_0000);
        fe(3'h4, 1'b1);
        p(3'b000, 3'h4, 1'b0);
        clrp();
        p(3'b000, 3'h4, 1'b0);
        rd(STATUS_OFS, 32'h0000_0403, 32'h0000_0703);
        sys_rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        p(3'b010, 3'h0, 1'b1);
        rd(CONFIG_OFS, 32'h0000_0000, 32'h0000_0101);
        rd(THRESH_OFS, 32'(THRESH_RST), 32'hFFFF_FFFF);
        bus(1'b1, CONFIG_OFS, 32'h0000_0004);
        p(3'b010, 3'h0, 1'b1);
        drive_enable_command_i <= 1'b1;
        pe = 2'h1;
        p(3'b000, 3'h0, 1'b1);
        polarity_done_i <= 1'b1;
        p(3'b010, 3'h0, 1'b1);
        {drive_enable_command_i, polarity_done_i} <= 2'b00;
        p(3'b000, 3'h0, 1'b1);
        drive_enable_command_i <= 1'b1;
        p(3'b000, 3'h0, 1'b1);
        summarize();
    end
    // Whole sequence runs in about 550 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fail("watchdog expired");
        summarize();
    end
endmodule
bind dso_status_top dso_status_props u_props (.clk_i, .sys_rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
    .fault_event_i, .fault_type_i, .fault_is_scale_i, .handheld_reset_i, .main_power_on_i, .safe_stop_in_a_i,
    .fault_status_out_o, .fault_code_bit0_o, .fault_code_bit1_o, .fault_code_bit2_o, .out_terminal_o);
